// *** logic/bte_consts.vh ***
// opcode, special register and reset constants for the branch and transfer execution unit
`ifndef BTE_CONSTS_VH
`define BTE_CONSTS_VH
`define BTE_OP_LONG_JUMP     8'h02
`define BTE_OP_LONG_CALL    8'h12
`define BTE_OP_RET      8'h22
`define BTE_OP_INTERRUPT_EXIT     8'h32
`define BTE_OP_JZ       8'h60
`define BTE_OP_JNZ      8'h70
`define BTE_OP_JMPI     8'h73
`define BTE_OP_MOVTP    8'h90
`define BTE_OP_COMPARE_BRANCH_UNEQUAL_AI  8'hB4
`define BTE_OP_COMPARE_BRANCH_UNEQUAL_AD  8'hB5
`define BTE_OP_PUSH     8'hC0
`define BTE_OP_XCH_D    8'hC5
`define BTE_OP_POP      8'hD0
`define BTE_OP_DECREMENT_LOOP_BRANCH_D   8'hD5
`define BTE_ABSOLUTE_JUMP_LO     5'h01
`define BTE_ABSOLUTE_CALL_LO    5'h11
`define BTE_GRP_XCH_RN  5'h19
`define BTE_GRP_DECREMENT_LOOP_BRANCH_RN 5'h1B
`define BTE_GRP_COMPARE_BRANCH_UNEQUAL_RN 5'h17
`define BTE_GRP_XCH_RI  7'h63
`define BTE_GRP_LOW_DIGIT_EXCHANGE_RI 7'h6B
`define BTE_GRP_COMPARE_BRANCH_UNEQUAL_RI 7'h5B
`define BTE_GRP_COMPARE_BRANCH_UNEQUAL_HI 4'hB
`define BTE_SFR_ACC     8'hE0
`define BTE_SFR_SP      8'h81
`define BTE_SFR_TPL     8'h82
`define BTE_SFR_TPH     8'h83
`define BTE_SFR_PSW     8'hD0
`define BTE_RST_SP      8'h07
`define BTE_PSW_CY      7
`define BTE_PSW_RS1     4
`define BTE_PSW_RS0     3
`define BTE_LEN1        2'h1
`define BTE_LEN2        2'h2
`define BTE_LEN3        2'h3
`endif

// *** logic/bte_exec.v ***
// branch and data transfer execution unit of the 8-bit core
// Notes on behaviour
// - push increments the stack pointer, then writes the byte at the new top.
// - pop reads the byte at the stack pointer, then decrements the stack pointer.
// - stack accesses are indirect, reaching all internal ram, never special registers.
// - table pointer load takes a 16-bit constant from the instruction stream.
// - byte exchange swaps accumulator with a direct, indirect or register byte.
// - low digit exchange swaps only bits 3:0 with the indirectly addressed byte.
// - long jump is three bytes and loads a full 16-bit target into pc.
// - absolute jump replaces low 11 pc bits, keeping the high 5 bits.
// - indexed jump loads pc with table pointer plus accumulator, 16-bit sum.
// - long call takes 16-bit address; absolute call stays within the 2K block.
// - subroutine exit resumes at the instruction after the entering call.
// - interrupt exit returns like subroutine exit and signals interrupt end.
// - conditional branches add a signed 8-bit offset to the next instruction address.
// - no zero flag; accumulator zero tests read the accumulator directly.
// - decrement loop branch decrements operand, branches when result is nonzero.
// - compare branch unequal branches when operands differ, else falls through.
// - compare is unsigned; carry set when first is below second, else cleared.
`timescale 1ns/1ps
`include "bte_consts.vh"
module bte_exec (
  input  wire        clock,
  input  wire        rst_n,
  output wire [15:0] code_addr,
  input  wire [7:0]  code_data,
  output reg  [7:0]  data_addr_ff,
  output reg         data_sfr_ff,
  output reg         data_we_ff,
  output reg  [7:0]  data_wdata_ff,
  input  wire [7:0]  data_rdata,
  output reg         interrupt_exit_done_ff,
  output reg  [15:0] pc_ff,
  output reg  [7:0]  acc_ff,
  output reg  [7:0]  sp_ff,
  output reg  [15:0] tp_ff,
  output reg  [7:0]  psw_ff
);
  // one-hot sequencer states
  localparam [9:0] S_FETCH  = 10'h001;
  localparam [9:0] S_BYTE1  = 10'h002;
  localparam [9:0] S_BYTE2  = 10'h004;
  localparam [9:0] S_PTR_A  = 10'h008;
  localparam [9:0] S_PTR_D  = 10'h010;
  localparam [9:0] S_OPND_A = 10'h020;
  localparam [9:0] S_OPND_D = 10'h040;
  localparam [9:0] S_EXEC   = 10'h080;
  localparam [9:0] S_STK    = 10'h100;
  localparam [9:0] S_RET_D  = 10'h200;

  reg        rst_meta_ff;
  reg        rst_sync_ff;
  reg [9:0]  state_ff;
  reg [7:0]  op_ff;
  reg [7:0]  b1_ff;
  reg [7:0]  b2_ff;
  reg [7:0]  ptr_ff;
  reg [7:0]  opnd_ff;
  reg [7:0]  hi_ff;
  reg [1:0]  left_ff;

  wire       is_absolute_jump  = (op_ff[4:0] == `BTE_ABSOLUTE_JUMP_LO);
  wire       is_absolute_call = (op_ff[4:0] == `BTE_ABSOLUTE_CALL_LO);
  wire       is_call  = is_absolute_call | (op_ff == `BTE_OP_LONG_CALL);
  wire       grp_rn   = (op_ff[7:3] == `BTE_GRP_XCH_RN) | (op_ff[7:3] == `BTE_GRP_DECREMENT_LOOP_BRANCH_RN) |
                        (op_ff[7:3] == `BTE_GRP_COMPARE_BRANCH_UNEQUAL_RN);
  wire       grp_ri   = (op_ff[7:1] == `BTE_GRP_XCH_RI) | (op_ff[7:1] == `BTE_GRP_LOW_DIGIT_EXCHANGE_RI) |
                        (op_ff[7:1] == `BTE_GRP_COMPARE_BRANCH_UNEQUAL_RI);
  wire       is_compare_branch_unequal  = (op_ff[7:4] == `BTE_GRP_COMPARE_BRANCH_UNEQUAL_HI) & (op_ff[3:2] != 2'h0);
  wire       is_decrement_loop_branch  = (op_ff == `BTE_OP_DECREMENT_LOOP_BRANCH_D) | (op_ff[7:3] == `BTE_GRP_DECREMENT_LOOP_BRANCH_RN);
  wire       is_xch   = (op_ff == `BTE_OP_XCH_D) | (op_ff[7:3] == `BTE_GRP_XCH_RN) |
                        (op_ff[7:1] == `BTE_GRP_XCH_RI);
  wire       is_low_digit_exchange  = (op_ff[7:1] == `BTE_GRP_LOW_DIGIT_EXCHANGE_RI);
  wire       is_ret   = (op_ff == `BTE_OP_RET) | (op_ff == `BTE_OP_INTERRUPT_EXIT);
  wire       dir_opnd = (op_ff == `BTE_OP_PUSH) | (op_ff == `BTE_OP_XCH_D) |
                        (op_ff == `BTE_OP_DECREMENT_LOOP_BRANCH_D) | (op_ff == `BTE_OP_COMPARE_BRANCH_UNEQUAL_AD);
  wire       needs_rd = dir_opnd | grp_rn | grp_ri | is_ret | (op_ff == `BTE_OP_POP);
  wire [7:0] rn_addr  = {3'h0, psw_ff[`BTE_PSW_RS1:`BTE_PSW_RS0], op_ff[2:0]};
  wire [7:0] ri_addr  = {3'h0, psw_ff[`BTE_PSW_RS1:`BTE_PSW_RS0], 2'h0, op_ff[0]};
  wire [9:0] prep     = grp_ri ? S_PTR_A : (needs_rd ? S_OPND_A : S_EXEC);
  wire [7:0] rel      = (is_compare_branch_unequal | (op_ff == `BTE_OP_DECREMENT_LOOP_BRANCH_D)) ? b2_ff : b1_ff;
  wire [15:0] rel_tgt = pc_ff + {{8{rel[7]}}, rel};
  wire [15:0] abs_tgt = {pc_ff[15:11], op_ff[7:5], b1_ff};
  wire [15:0] call_tgt = is_absolute_call ? abs_tgt : {b1_ff, b2_ff};
  wire [7:0] dec_val  = opnd_ff - 8'h01;
  wire [7:0] cmp_a    = ((op_ff == `BTE_OP_COMPARE_BRANCH_UNEQUAL_AI) | (op_ff == `BTE_OP_COMPARE_BRANCH_UNEQUAL_AD)) ?
                        acc_ff : opnd_ff;
  wire [7:0] cmp_b    = (op_ff == `BTE_OP_COMPARE_BRANCH_UNEQUAL_AD) ? opnd_ff : b1_ff;
  wire [7:0] sp_inc   = sp_ff + 8'h01;
  wire [7:0] sp_dec   = sp_ff - 8'h01;

  // decoded operations and branch conditions
  wire       is_long_jump  = (op_ff == `BTE_OP_LONG_JUMP);
  wire       is_interrupt_exit  = (op_ff == `BTE_OP_INTERRUPT_EXIT);
  wire       is_jmpi  = (op_ff == `BTE_OP_JMPI);
  wire       is_movtp = (op_ff == `BTE_OP_MOVTP);
  wire       is_jz    = (op_ff == `BTE_OP_JZ);
  wire       is_jnz   = (op_ff == `BTE_OP_JNZ);
  wire       is_push  = (op_ff == `BTE_OP_PUSH);
  wire       is_pop   = (op_ff == `BTE_OP_POP);
  wire       acc_zero = (acc_ff == 8'h00);
  wire       dec_nz   = (dec_val != 8'h00);
  wire       cmp_ne   = (cmp_a != cmp_b);
  wire       cmp_lt   = (cmp_a < cmp_b);
  wire [15:0] imm16   = {b1_ff, b2_ff};
  wire [15:0] idx_tgt = tp_ff + {8'h00, acc_ff};
  wire [15:0] ret_tgt = {hi_ff, data_rdata};
  wire [7:0] low_digit_exchange_acc = {acc_ff[7:4], opnd_ff[3:0]};
  wire [7:0] low_digit_exchange_mem = {opnd_ff[7:4], acc_ff[3:0]};


  assign code_addr = pc_ff;

  // instruction length from a freshly fetched opcode
  function [1:0] f_len;
    input [7:0] o;
    begin
      case (o)
        `BTE_OP_LONG_JUMP, `BTE_OP_LONG_CALL, `BTE_OP_MOVTP, `BTE_OP_DECREMENT_LOOP_BRANCH_D:
          f_len = `BTE_LEN3;
        `BTE_OP_JZ, `BTE_OP_JNZ, `BTE_OP_PUSH, `BTE_OP_POP, `BTE_OP_XCH_D:
          f_len = `BTE_LEN2;
        default: begin
          if ((o[7:4] == `BTE_GRP_COMPARE_BRANCH_UNEQUAL_HI) & (o[3:2] != 2'h0))
            f_len = `BTE_LEN3;
          else if ((o[4:0] == `BTE_ABSOLUTE_JUMP_LO) | (o[4:0] == `BTE_ABSOLUTE_CALL_LO) |
                   (o[7:3] == `BTE_GRP_DECREMENT_LOOP_BRANCH_RN))
            f_len = `BTE_LEN2;
          else
            f_len = `BTE_LEN1;
        end
      endcase
    end
  endfunction

  // special registers held inside the unit
  function f_hit;
    input [7:0] a;
    input       s;
    begin
      f_hit = s & ((a == `BTE_SFR_ACC) | (a == `BTE_SFR_SP) | (a == `BTE_SFR_TPL) |
                   (a == `BTE_SFR_TPH) | (a == `BTE_SFR_PSW));
    end
  endfunction

  // operand read value, internal registers override the data port
  reg [7:0] rd_val;
  always @* begin
    rd_val = data_rdata;
    if (data_sfr_ff) begin
      case (data_addr_ff)
        `BTE_SFR_ACC: rd_val = acc_ff;
        `BTE_SFR_SP:  rd_val = sp_ff;
        `BTE_SFR_TPL: rd_val = tp_ff[7:0];
        `BTE_SFR_TPH: rd_val = tp_ff[15:8];
        `BTE_SFR_PSW: rd_val = psw_ff;
        default:      rd_val = data_rdata;
      endcase
    end
  end

  // store a byte to internal register or data port
  task put;
    input [7:0] a;
    input       s;
    input [7:0] v;
    begin
      data_addr_ff  <= a;
      data_sfr_ff   <= s;
      data_wdata_ff <= v;
      if (f_hit(a, s)) begin
        case (a)
          `BTE_SFR_ACC: acc_ff <= v;
          `BTE_SFR_SP:  sp_ff <= v;
          `BTE_SFR_TPL: tp_ff[7:0] <= v;
          `BTE_SFR_TPH: tp_ff[15:8] <= v;
          default:      psw_ff <= v;
        endcase
      end else begin
        data_we_ff <= 1'b1;
      end
    end
  endtask

  // reset released through two flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // instruction sequencer, one state per clock
  always @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff      <= S_FETCH;
      op_ff         <= 8'h00;
      b1_ff         <= 8'h00;
      b2_ff         <= 8'h00;
      ptr_ff        <= 8'h00;
      opnd_ff       <= 8'h00;
      hi_ff         <= 8'h00;
      left_ff       <= 2'h0;
      data_addr_ff  <= 8'h00;
      data_sfr_ff   <= 1'b0;
      data_we_ff    <= 1'b0;
      data_wdata_ff <= 8'h00;
      interrupt_exit_done_ff  <= 1'b0;
      pc_ff         <= 16'h0000;
      acc_ff        <= 8'h00;
      sp_ff         <= `BTE_RST_SP;
      tp_ff         <= 16'h0000;
      psw_ff        <= 8'h00;
    end else begin
      data_we_ff   <= 1'b0;
      interrupt_exit_done_ff <= 1'b0;
      case (state_ff)
        S_FETCH: begin
          op_ff   <= code_data;
          pc_ff   <= pc_ff + 16'h0001;
          left_ff <= f_len(code_data);
          if (f_len(code_data) == `BTE_LEN1) begin
            state_ff <= S_BYTE2;
          end else begin
            state_ff <= S_BYTE1;
          end
        end
        S_BYTE1: begin
          b1_ff <= code_data;
          pc_ff <= pc_ff + 16'h0001;
          state_ff <= (left_ff == `BTE_LEN3) ? S_BYTE2 : prep;
        end
        S_BYTE2: begin
          if (left_ff == `BTE_LEN3) begin
            b2_ff <= code_data;
            pc_ff <= pc_ff + 16'h0001;
          end
          state_ff <= prep;
        end
        // indirect pointer register read
        S_PTR_A: begin
          data_addr_ff <= ri_addr;
          data_sfr_ff  <= 1'b0;
          state_ff     <= S_PTR_D;
        end
        S_PTR_D: begin
          ptr_ff   <= data_rdata;
          state_ff <= S_OPND_A;
        end
        // operand address by addressing mode
        S_OPND_A: begin
          state_ff <= S_OPND_D;
          if (grp_ri) begin
            data_addr_ff <= ptr_ff;
            data_sfr_ff  <= 1'b0;
          end else if (grp_rn) begin
            data_addr_ff <= rn_addr;
            data_sfr_ff  <= 1'b0;
          end else if (dir_opnd) begin
            data_addr_ff <= b1_ff;
            data_sfr_ff  <= b1_ff[7];
          end else begin
            data_addr_ff <= sp_ff;
            data_sfr_ff  <= 1'b0;
          end
        end
        S_OPND_D: begin
          opnd_ff  <= rd_val;
          state_ff <= S_EXEC;
        end
        // register effects of the instruction
        S_EXEC: begin
          state_ff <= S_FETCH;
          if (is_long_jump)
            pc_ff <= imm16;
          else if (is_absolute_jump)
            pc_ff <= abs_tgt;
          else if (is_jmpi)
            pc_ff <= idx_tgt;
          else if (is_movtp)
            tp_ff <= imm16;
          else if (is_jz) begin
            if (acc_zero)
              pc_ff <= rel_tgt;
          end else if (is_jnz) begin
            if (!acc_zero)
              pc_ff <= rel_tgt;
          end else if (is_push) begin
            sp_ff <= sp_inc;
            put(sp_inc, 1'b0, opnd_ff);
          end else if (is_pop) begin
            sp_ff <= sp_dec;
            put(b1_ff, b1_ff[7], opnd_ff);
          end else if (is_xch) begin
            acc_ff <= opnd_ff;
            put(data_addr_ff, data_sfr_ff, acc_ff);
          end else if (is_low_digit_exchange) begin
            acc_ff <= low_digit_exchange_acc;
            put(data_addr_ff, 1'b0, low_digit_exchange_mem);
          end else if (is_decrement_loop_branch) begin
            put(data_addr_ff, data_sfr_ff, dec_val);
            if (dec_nz)
              pc_ff <= rel_tgt;
          end else if (is_compare_branch_unequal) begin
            psw_ff[`BTE_PSW_CY] <= cmp_lt;
            if (cmp_ne)
              pc_ff <= rel_tgt;
          end else if (is_call) begin
            sp_ff <= sp_inc;
            put(sp_inc, 1'b0, pc_ff[7:0]);
            state_ff <= S_STK;
          end else if (is_ret) begin
            hi_ff        <= opnd_ff;
            sp_ff        <= sp_dec;
            data_addr_ff <= sp_dec;
            data_sfr_ff  <= 1'b0;
            state_ff     <= S_RET_D;
          end
        end
        // second call cycle pushes the high return byte
        S_STK: begin
          sp_ff <= sp_inc;
          put(sp_inc, 1'b0, pc_ff[15:8]);
          pc_ff    <= call_tgt;
          state_ff <= S_FETCH;
        end
        // return low byte read at the decremented top
        S_RET_D: begin
          pc_ff    <= ret_tgt;
          sp_ff    <= sp_dec;
          interrupt_exit_done_ff <= is_interrupt_exit;
          state_ff <= S_FETCH;
        end
        default: state_ff <= S_FETCH;
      endcase
    end
  end
endmodule // bte_exec

// *** verification/bte_exec_monitor.sv ***
// concurrent checks on the ports of the branch and transfer unit
`timescale 1ns/1ps
`include "bte_consts.vh"
module bte_exec_monitor (
  input wire        clock,
  input wire        rst_n,
  input wire [15:0] code_addr,
  input wire [7:0]  data_addr_ff,
  input wire        data_sfr_ff,
  input wire        data_we_ff,
  input wire        interrupt_exit_done_ff,
  input wire [15:0] pc_ff,
  input wire [7:0]  sp_ff,
  input wire [7:0]  psw_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_push_write: assert property (
    sp_ff == $past(sp_ff) + 8'h01 |-> data_we_ff && data_addr_ff == sp_ff)
    else $error("stack step without write at new top");
  a_stack_in_ram: assert property (
    sp_ff == $past(sp_ff) + 8'h01 |-> !data_sfr_ff)
    else $error("stack write went to register space");
  a_pop_no_write: assert property (
    sp_ff == $past(sp_ff) - 8'h01 |-> !(data_we_ff && data_addr_ff == $past(sp_ff)))
    else $error("pop wrote over the old top");
  a_interrupt_exit_single: assert property (
    interrupt_exit_done_ff |=> !interrupt_exit_done_ff [*2])
    else $error("interrupt end pulse too long");
  a_interrupt_exit_quiet: assert property (
    interrupt_exit_done_ff |-> !data_we_ff)
    else $error("write during interrupt end");
  a_code_follows_pc: assert property (code_addr == pc_ff)
    else $error("code address differs from pc");
  a_no_internal_write: assert property (data_we_ff && data_sfr_ff |->
    !(data_addr_ff inside {`BTE_SFR_ACC, `BTE_SFR_SP, `BTE_SFR_TPL, `BTE_SFR_TPH,
    `BTE_SFR_PSW}))
    else $error("memory write to internal register");
  a_reset_state: assert property ($rose(rst_n) |-> sp_ff == `BTE_RST_SP && pc_ff == 16'h0000)
    else $error("bad state at reset release");
  a_psw_no_zero: assert property (
    $stable(psw_ff[6:0]))
    else $error("status bits other than carry changed");
endmodule // bte_exec_monitor
bind bte_exec bte_exec_monitor mon_u (.clock(clock), .rst_n(rst_n), .code_addr(code_addr),
  .data_addr_ff(data_addr_ff), .data_sfr_ff(data_sfr_ff), .data_we_ff(data_we_ff),
  .interrupt_exit_done_ff(interrupt_exit_done_ff), .pc_ff(pc_ff), .sp_ff(sp_ff), .psw_ff(psw_ff));

// *** verification/bte_mem_model.sv ***
// program and internal data memory facing the execution unit
`timescale 1ns/1ps
module bte_mem_model (
  input  wire        clock,
  input  wire [15:0] code_addr,
  output wire [7:0]  code_data,
  input  wire [7:0]  data_addr_ff,
  input  wire        data_sfr_ff,
  input  wire        data_we_ff,
  input  wire [7:0]  data_wdata_ff,
  output wire [7:0]  data_rdata
);
  logic [7:0] rom [0:65535];
  logic [7:0] ram [0:255];
  logic [7:0] sfr [0:255];
  assign code_data = rom[code_addr];
  // ram and register space kept apart
  assign data_rdata = data_sfr_ff ? sfr[data_addr_ff] : ram[data_addr_ff];
  always @(posedge clock) begin
    if (data_we_ff && data_sfr_ff) sfr[data_addr_ff] <= data_wdata_ff;
    if (data_we_ff && !data_sfr_ff) ram[data_addr_ff] <= data_wdata_ff;
  end
endmodule // bte_mem_model

// *** verification/testbench.sv ***
// self-checking bench for the branch and transfer execution unit
`timescale 1ns/1ps
`include "bte_consts.vh"
module testbench;
  typedef struct packed {
    logic [47:0] p;
    logic [15:0] t;
    logic [7:0]  a;
    logic [7:0]  s;
    logic [15:0] d;
    logic        c;
    logic [7:0]  ra;
    logic [7:0]  rv;
  } bte_row_t;
  logic        clock;
  logic        rst_n;
  wire  [15:0] code_addr;
  wire  [7:0]  code_data;
  wire  [7:0]  data_addr_ff;
  wire         data_sfr_ff;
  wire         data_we_ff;
  wire  [7:0]  data_wdata_ff;
  wire  [7:0]  data_rdata;
  wire         interrupt_exit_done_ff;
  wire  [15:0] pc_ff;
  wire  [7:0]  acc_ff;
  wire  [7:0]  sp_ff;
  wire  [15:0] tp_ff;
  wire  [7:0]  psw_ff;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  bte_row_t    rows [26] = '{
    {48'h021234000000, 16'h1234, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'hC04000000000, 16'h0002, 8'h00, 8'h08, 16'h0000, 1'b0, 8'h08, 8'h20},
    {48'hC040C041D0E0, 16'h0006, 8'h21, 8'h08, 16'h0000, 1'b0, 8'h09, 8'h21},
    {48'hD0E000000000, 16'h0002, 8'hE7, 8'h06, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'h90ABCD000000, 16'h0003, 8'h00, 8'h07, 16'hABCD, 1'b0, 8'h07, 8'hE7},
    {48'hC54000000000, 16'h0002, 8'h20, 8'h07, 16'h0000, 1'b0, 8'h40, 8'h00},
    {48'hC541D6000000, 16'h0003, 8'h20, 8'h07, 16'h0000, 1'b0, 8'hE0, 8'hC1},
    {48'hA12300000000, 16'h0523, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'h9012F0C54173, 16'h1311, 8'h21, 8'h07, 16'h12F0, 1'b0, 8'h07, 8'hE7},
    {48'h120100000000, 16'h0003, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h08, 8'h03},
    {48'h318000000000, 16'h0002, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h09, 8'h00},
    {48'h601000000000, 16'h0012, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'hC54170800000, 16'hFF84, 8'h21, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'hC541607F0000, 16'h0004, 8'h21, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'hD52110000000, 16'h0003, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h21, 8'h00},
    {48'hD54010000000, 16'h0013, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h40, 8'h1F},
    {48'hB40510000000, 16'h0013, 8'h00, 8'h07, 16'h0000, 1'b1, 8'h07, 8'hE7},
    {48'hB40010000000, 16'h0003, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'hC541B4051000, 16'h0015, 8'h21, 8'h07, 16'h0000, 1'b0, 8'h07, 8'hE7},
    {48'hC90000000000, 16'h0001, 8'hE1, 8'h07, 16'h0000, 1'b0, 8'h01, 8'h00},
    {48'hC70000000000, 16'h0001, 8'hC1, 8'h07, 16'h0000, 1'b0, 8'hE1, 8'h00},
    {48'hDA1000000000, 16'h0012, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h02, 8'hE1},
    {48'hB54010000000, 16'h0013, 8'h00, 8'h07, 16'h0000, 1'b1, 8'h40, 8'h20},
    {48'hBBE3F0000000, 16'h0003, 8'h00, 8'h07, 16'h0000, 1'b0, 8'h03, 8'hE3},
    {48'hB6C1F0000000, 16'hFFF3, 8'h00, 8'h07, 16'h0000, 1'b1, 8'hE0, 8'hC0},
    {48'hD08100000000, 16'h0002, 8'h00, 8'hE7, 16'h0000, 1'b0, 8'h07, 8'hE7}
  };
  bte_exec dut_u (.clock(clock), .rst_n(rst_n), .code_addr(code_addr), .code_data(code_data),
    .data_addr_ff(data_addr_ff), .data_sfr_ff(data_sfr_ff), .data_we_ff(data_we_ff),
    .data_wdata_ff(data_wdata_ff), .data_rdata(data_rdata), .interrupt_exit_done_ff(interrupt_exit_done_ff),
    .pc_ff(pc_ff), .acc_ff(acc_ff), .sp_ff(sp_ff), .tp_ff(tp_ff), .psw_ff(psw_ff));
  bte_mem_model mem_u (.clock(clock), .code_addr(code_addr), .code_data(code_data),
    .data_addr_ff(data_addr_ff), .data_sfr_ff(data_sfr_ff), .data_we_ff(data_we_ff),
    .data_wdata_ff(data_wdata_ff), .data_rdata(data_rdata));
  task automatic give_verdict;
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // fresh memory image: program at zero, subroutines, self loop at the target
  task automatic load(input bte_row_t r);
    int i;
    for (i = 0; i < 65536; i++) mem_u.rom[i] = 8'h00;
    for (i = 0; i < 256; i++) mem_u.ram[i] = 8'(i) - 8'h20;
    for (i = 0; i < 6; i++) mem_u.rom[i] = r.p[47-8*i -: 8];
    mem_u.rom[16'h0100] = `BTE_OP_RET;
    mem_u.rom[16'h0180] = `BTE_OP_INTERRUPT_EXIT;
    mem_u.rom[r.t] = `BTE_OP_LONG_JUMP;
    mem_u.rom[r.t + 16'h0001] = r.t[15:8];
    mem_u.rom[r.t + 16'h0002] = r.t[7:0];
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    int k;
    int n;
    int r;
    rst_n = 1'b0;
    repeat (12) @(negedge clock);
    chk(pc_ff, 16'h0000);
    chk({8'h00, sp_ff}, {8'h00, `BTE_RST_SP});
    chk({acc_ff, psw_ff}, 16'h0000);
    chk(tp_ff, 16'h0000);
    chk({14'h0000, data_we_ff, interrupt_exit_done_ff}, 16'h0000);
    for (k = 0; k < 26; k++) begin
      load(rows[k]);
      rst_n = 1'b1;
      r = 0;
      repeat (40) begin
        @(negedge clock);
        if (interrupt_exit_done_ff === 1'b1)
          r++;
      end
      n = 0;
      while (pc_ff !== rows[k].t && n < 8) begin
        @(negedge clock);
        n++;
      end
      chk(pc_ff, rows[k].t);
      chk({8'h00, acc_ff}, {8'h00, rows[k].a});
      chk({8'h00, sp_ff}, {8'h00, rows[k].s});
      chk(tp_ff, rows[k].d);
      chk({15'h0000, psw_ff[`BTE_PSW_CY]}, {15'h0000, rows[k].c});
      chk({8'h00, mem_u.ram[rows[k].ra]}, {8'h00, rows[k].rv});
      chk(r[15:0], (k == 10) ? 16'h0001 : 16'h0000);
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
    end
    // reset in mid-program, then the two-flop release
    load(rows[2]);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    chk(pc_ff, 16'h0000);
    chk({8'h00, sp_ff}, {8'h00, `BTE_RST_SP});
    chk({acc_ff, psw_ff}, 16'h0000);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    chk(pc_ff, 16'h0000);
    @(negedge clock);
    chk(pc_ff, 16'h0001);
    give_verdict;
  end
endmodule // testbench
